// ### design/cta_pkg.sv
// Shared constants and types of the counter array time base.
package cta_pkg;

    // Register addresses on the special function register port.
    localparam logic [7:0] CTA_ADDR_CTRL = 8'hD8;
    localparam logic [7:0] CTA_ADDR_MODE = 8'hD9;
    localparam logic [7:0] CTA_ADDR_MOD0 = 8'hDA;
    localparam logic [7:0] CTA_ADDR_MOD5 = 8'hDF;
    localparam logic [7:0] CTA_ADDR_CNT_HI = 8'hF9;
    localparam logic [7:0] CTA_ADDR_CNT_LO = 8'hE9;
    localparam logic [7:0] CTA_ADDR_RLD_HI = 8'hCF;
    localparam logic [7:0] CTA_ADDR_RLD_LO = 8'hCE;

    // Values after reset.
    localparam logic [7:0] CTA_CTRL_RST = 8'h00;
    localparam logic [7:0] CTA_MODE_RST = 8'h00;
    localparam logic [7:0] CTA_MOD_RST = 8'h00;
    localparam logic [7:0] CTA_BYTE_RST = 8'h00;

    // Field positions in the control register.
    localparam int CTA_CTRL_FLAG_POS = 7;
    localparam int CTA_CTRL_RUN_POS = 6;

    // Counter geometry and module count.
    localparam int CTA_NMOD = 6;
    localparam logic [15:0] CTA_CNT_TOP = 16'hFFFF;
    localparam logic [5:0] CTA_CAPTURE_CAPABLE = 6'h3F;

    // Prescaler counts.
    localparam logic [3:0] CTA_DIV12_LAST = 4'hB;
    localparam logic [3:0] CTA_DIV2_LAST = 4'h1;

    // Counter source codes.
    typedef enum logic [2:0] {
        CTA_SRC_DIV12 = 3'h0,
        CTA_SRC_DIV2 = 3'h1,
        CTA_SRC_T0OVF = 3'h2,
        CTA_SRC_EXTPIN = 3'h3,
        CTA_SRC_MIXTICK = 3'h4,
        CTA_SRC_SYSTEM_CLOCK = 3'h5,
        CTA_SRC_S0OVF = 3'h6,
        CTA_SRC_MDIV = 3'h7
    } cta_src_t;

    // Mode register layout.
    typedef struct packed {
        logic idle_gate_enable;
        logic pair45_buffer_enable;
        logic pair23_buffer_enable;
        logic pair01_buffer_enable;
        cta_src_t source_select;
        logic overflow_irq_enable;
    } cta_mode_t;

    // Per-module mode register layout.
    typedef struct packed {
        logic dead_time_enable;
        logic compare_enable;
        logic capture_rise;
        logic capture_fall;
        logic match_sets_flag;
        logic toggle_on_match;
        logic pwm_enable;
        logic module_irq_enable;
    } cta_modmode_t;

    // Raw count sources, all sampled on the system clock.
    typedef struct packed {
        logic timer0_overflow;
        logic serial0_baud_overflow;
        logic external_count_pin;
        logic mixed_tick_clock;
        logic master_divider_out;
    } cta_srcs_t;

endpackage : cta_pkg

// ### design/cta_src_sel.sv
// Counter input selection, prescaling and event synchronisation.
`timescale 1ns/100ps
module cta_src_sel
    import cta_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Sources and selection
    input wire cta_srcs_t srcs,
    input wire cta_src_t sel,
    // One pulse per count event
    output logic tick
);

    logic [3:0] pre_r;
    logic div12_r;
    logic div2_r;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync3_r;
    logic [2:0] t_ovf_r;
    logic tick_nxt;

    // Free-running prescaler so each divided source is a one-cycle pulse.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_r <= 4'h0;
            div12_r <= 1'b0;
            div2_r <= 1'b0;
        end else begin
            pre_r <= (pre_r == CTA_DIV12_LAST) ? 4'h0 : pre_r + 4'h1;
            div12_r <= (pre_r == CTA_DIV12_LAST);
            div2_r <= (pre_r[0] == CTA_DIV2_LAST[0]);
        end
    end

    // Two-stage synchronisers for the level sources, plus a history stage.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            sync3_r <= 3'h0;
            t_ovf_r <= 3'h0;
        end else begin
            sync1_r <= {srcs.external_count_pin, srcs.mixed_tick_clock,
                        srcs.master_divider_out};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            t_ovf_r <= {srcs.timer0_overflow, srcs.serial0_baud_overflow, 1'b0};
        end
    end

    always_comb begin
        unique case (sel)
            CTA_SRC_DIV12: tick_nxt = div12_r;
            CTA_SRC_DIV2: tick_nxt = div2_r;
            CTA_SRC_T0OVF: tick_nxt = t_ovf_r[2];
            CTA_SRC_EXTPIN: tick_nxt = sync3_r[2] & ~sync2_r[2];
            CTA_SRC_MIXTICK: tick_nxt = sync2_r[1] & ~sync3_r[1];
            CTA_SRC_SYSTEM_CLOCK: tick_nxt = 1'b1;
            CTA_SRC_S0OVF: tick_nxt = t_ovf_r[1];
            CTA_SRC_MDIV: tick_nxt = sync2_r[0] & ~sync3_r[0];
        endcase
    end

    // One count event per selected source event, on the system clock.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick <= 1'b0;
        end else begin
            tick <= tick_nxt;
        end
    end

endmodule : cta_src_sel

// ### design/cta_time_base.sv
// Counter array time base with control, mode and module flag logic.
`timescale 1ns/100ps
module cta_time_base
    import cta_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Special function register port
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    // Count sources and processor state
    input wire cta_srcs_t COUNT_SOURCES,
    input wire logic IDLE,
    // Module side
    input wire logic [CTA_NMOD-1:0][15:0] MODULE_COMPARE,
    input wire logic [CTA_NMOD-1:0] MODULE_PIN_IN,
    output logic [CTA_NMOD-1:0] MODULE_PIN_OWNED,
    output logic [CTA_NMOD-1:0] MODULE_PIN_OUT,
    output logic [15:0] TIME_BASE,
    output logic [2:0] PAIR_BUFFER_ACTIVE,
    // Clock output and interrupt
    output logic OVERFLOW_CLOCK_OUT,
    output logic OVERFLOW_CLOCK_OE,
    output logic IRQ
);

    cta_mode_t mode_r;
    logic overflow_flag_r;
    logic counter_run_r;
    logic [CTA_NMOD-1:0] module_event_flag_r;
    cta_modmode_t [CTA_NMOD-1:0] modmode_r;
    logic [7:0] count_high_byte_r;
    logic [7:0] count_low_byte_r;
    logic [7:0] reload_high_byte_r;
    logic [7:0] reload_low_byte_r;
    logic overflow_toggle_bit_r;
    logic overflow_clock_out_enable_r;
    logic stepped_r;
    logic [CTA_NMOD-1:0] pin_prev_r;
    logic tick;
    logic count_enable;
    logic overflow;
    logic [15:0] count;
    logic [15:0] count_nxt;
    logic [CTA_NMOD-1:0] match_evt;
    logic [CTA_NMOD-1:0] capture_evt;
    logic [CTA_NMOD-1:0] flag_nxt;
    logic overflow_flag_nxt;
    logic [7:0] rdata_nxt;

    function automatic logic wr_hit(input logic [7:0] addr);
        wr_hit = SFR_WR && (SFR_ADDR == addr);
    endfunction : wr_hit

    // A module qualifies for buffering in capture (rising or falling edge) or PWM mode.
    function automatic logic buf_ok(input cta_modmode_t m);
        buf_ok = m.capture_rise | m.capture_fall | m.pwm_enable;
    endfunction : buf_ok

    cta_src_sel u_src_sel (
        .clk(CLK),
        .rst_b(RST_B),
        .srcs(COUNT_SOURCES),
        .sel(mode_r.source_select),
        .tick(tick)
    );

    assign count = {count_high_byte_r, count_low_byte_r};
    assign count_enable = tick && counter_run_r && !(mode_r.idle_gate_enable && IDLE);
    assign overflow = count_enable && (count == CTA_CNT_TOP);
    assign count_nxt = overflow ? {reload_high_byte_r, reload_low_byte_r} : count + 16'h0001;

    // Mode register.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            mode_r <= cta_mode_t'(CTA_MODE_RST);
        end else if (wr_hit(CTA_ADDR_MODE)) begin
            mode_r <= cta_mode_t'(SFR_WDATA);
        end
    end

    // No register of this block writes the clock output enable, so the pin stays general I/O.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            overflow_clock_out_enable_r <= 1'b0;
        end else begin
            overflow_clock_out_enable_r <= overflow_clock_out_enable_r;
        end
    end

    // Per-module mode registers.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            modmode_r <= '0;
        end else begin
            for (int i = 0; i < CTA_NMOD; i++) begin
                if (wr_hit(CTA_ADDR_MOD0 + 8'(i))) begin
                    modmode_r[i] <= cta_modmode_t'(SFR_WDATA);
                end
            end
        end
    end

    // Counter bytes: a software write wins over a count in the same cycle.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            count_high_byte_r <= CTA_BYTE_RST;
            count_low_byte_r <= CTA_BYTE_RST;
        end else begin
            if (wr_hit(CTA_ADDR_CNT_HI)) begin
                count_high_byte_r <= SFR_WDATA;
            end else if (count_enable) begin
                count_high_byte_r <= count_nxt[15:8];
            end
            if (wr_hit(CTA_ADDR_CNT_LO)) begin
                count_low_byte_r <= SFR_WDATA;
            end else if (count_enable) begin
                count_low_byte_r <= count_nxt[7:0];
            end
        end
    end

    // Reload bytes.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            reload_high_byte_r <= CTA_BYTE_RST;
            reload_low_byte_r <= CTA_BYTE_RST;
        end else begin
            if (wr_hit(CTA_ADDR_RLD_HI)) begin
                reload_high_byte_r <= SFR_WDATA;
            end
            if (wr_hit(CTA_ADDR_RLD_LO)) begin
                reload_low_byte_r <= SFR_WDATA;
            end
        end
    end

    // Matches are taken once per counter step, not for every cycle held equal.
    always_comb begin
        for (int i = 0; i < CTA_NMOD; i++) begin
            match_evt[i] = stepped_r && modmode_r[i].compare_enable
                && (count == MODULE_COMPARE[i]);
            capture_evt[i] = CTA_CAPTURE_CAPABLE[i]
                && ((modmode_r[i].capture_rise && MODULE_PIN_IN[i] && !pin_prev_r[i])
                || (modmode_r[i].capture_fall && !MODULE_PIN_IN[i] && pin_prev_r[i]));
        end
    end

    // Flags: a hardware set wins over a software clear in the same cycle.
    always_comb begin
        overflow_flag_nxt = overflow_flag_r;
        flag_nxt = module_event_flag_r;
        if (wr_hit(CTA_ADDR_CTRL)) begin
            overflow_flag_nxt = SFR_WDATA[CTA_CTRL_FLAG_POS];
            flag_nxt = SFR_WDATA[CTA_NMOD-1:0];
        end
        overflow_flag_nxt = overflow_flag_nxt | overflow;
        for (int i = 0; i < CTA_NMOD; i++) begin
            flag_nxt[i] = flag_nxt[i]
                | (match_evt[i] && modmode_r[i].match_sets_flag)
                | capture_evt[i];
        end
    end

    // Control register.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            overflow_flag_r <= CTA_CTRL_RST[CTA_CTRL_FLAG_POS];
            counter_run_r <= CTA_CTRL_RST[CTA_CTRL_RUN_POS];
            module_event_flag_r <= CTA_CTRL_RST[CTA_NMOD-1:0];
        end else begin
            overflow_flag_r <= overflow_flag_nxt;
            module_event_flag_r <= flag_nxt;
            if (wr_hit(CTA_ADDR_CTRL)) begin
                counter_run_r <= SFR_WDATA[CTA_CTRL_RUN_POS];
            end
        end
    end

    // Step marker and pin history for edge capture.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            stepped_r <= 1'b0;
            pin_prev_r <= '0;
        end else begin
            stepped_r <= count_enable;
            pin_prev_r <= MODULE_PIN_IN;
        end
    end

    // Overflow clock output.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            overflow_toggle_bit_r <= 1'b0;
            OVERFLOW_CLOCK_OUT <= 1'b0;
            OVERFLOW_CLOCK_OE <= 1'b0;
        end else begin
            if (overflow) begin
                overflow_toggle_bit_r <= ~overflow_toggle_bit_r;
            end
            OVERFLOW_CLOCK_OUT <= overflow_toggle_bit_r;
            OVERFLOW_CLOCK_OE <= overflow_clock_out_enable_r;
        end
    end

    // Module pins: toggled on match, claimed only while a mode drives them.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            MODULE_PIN_OUT <= '0;
            MODULE_PIN_OWNED <= '0;
        end else begin
            for (int i = 0; i < CTA_NMOD; i++) begin
                if (match_evt[i] && modmode_r[i].toggle_on_match) begin
                    MODULE_PIN_OUT[i] <= ~MODULE_PIN_OUT[i];
                end
                MODULE_PIN_OWNED[i] <= modmode_r[i].toggle_on_match
                    | modmode_r[i].pwm_enable;
            end
        end
    end

    // Buffer mode of each pair, time base copy and interrupt.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            PAIR_BUFFER_ACTIVE <= 3'h0;
            TIME_BASE <= 16'h0000;
            IRQ <= 1'b0;
        end else begin
            PAIR_BUFFER_ACTIVE[0] <= mode_r.pair01_buffer_enable
                && buf_ok(modmode_r[0]) && buf_ok(modmode_r[1]);
            PAIR_BUFFER_ACTIVE[1] <= mode_r.pair23_buffer_enable
                && buf_ok(modmode_r[2]) && buf_ok(modmode_r[3]);
            PAIR_BUFFER_ACTIVE[2] <= mode_r.pair45_buffer_enable
                && buf_ok(modmode_r[4]) && buf_ok(modmode_r[5]);
            TIME_BASE <= count_nxt_or_hold();
            IRQ <= (overflow_flag_nxt && mode_r.overflow_irq_enable)
                || |(flag_nxt & module_irq_mask());
        end
    end

    function automatic logic [15:0] count_nxt_or_hold();
        count_nxt_or_hold = count_enable ? count_nxt : count;
    endfunction : count_nxt_or_hold

    function automatic logic [CTA_NMOD-1:0] module_irq_mask();
        for (int i = 0; i < CTA_NMOD; i++) begin
            module_irq_mask[i] = modmode_r[i].module_irq_enable;
        end
    endfunction : module_irq_mask

    // Read data, registered; unmapped addresses read zero.
    always_comb begin
        rdata_nxt = 8'h00;
        if (SFR_ADDR == CTA_ADDR_CTRL) begin
            rdata_nxt = {overflow_flag_r, counter_run_r, module_event_flag_r};
        end else if (SFR_ADDR == CTA_ADDR_MODE) begin
            rdata_nxt = mode_r;
        end else if (SFR_ADDR >= CTA_ADDR_MOD0 && SFR_ADDR <= CTA_ADDR_MOD5) begin
            rdata_nxt = modmode_r[3'(SFR_ADDR - CTA_ADDR_MOD0)];
        end else if (SFR_ADDR == CTA_ADDR_CNT_HI) begin
            rdata_nxt = count_high_byte_r;
        end else if (SFR_ADDR == CTA_ADDR_CNT_LO) begin
            rdata_nxt = count_low_byte_r;
        end else if (SFR_ADDR == CTA_ADDR_RLD_HI) begin
            rdata_nxt = reload_high_byte_r;
        end else if (SFR_ADDR == CTA_ADDR_RLD_LO) begin
            rdata_nxt = reload_low_byte_r;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            SFR_RDATA <= 8'h00;
        end else if (SFR_RD) begin
            SFR_RDATA <= rdata_nxt;
        end
    end

endmodule : cta_time_base

// ### testbench/cta_time_base_monitor.sv
// Port-level checker of the counter array time base.
`timescale 1ns/100ps
module cta_time_base_monitor
    import cta_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Register port and processor state
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic IDLE,
    // Watched outputs
    input wire logic [15:0] TIME_BASE,
    input wire logic OVERFLOW_CLOCK_OUT,
    input wire logic OVERFLOW_CLOCK_OE,
    input wire logic IRQ
);
    logic [7:0] mode_r;
    logic [5:0] eccf_r;
    logic [15:0] reload_r;
    logic run_r;
    logic cnt_wr;
    assign cnt_wr = SFR_WR && (SFR_ADDR == CTA_ADDR_CNT_HI || SFR_ADDR == CTA_ADDR_CNT_LO);
    // Shadows of what software wrote, used as the cause side of the checks.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            mode_r <= 8'h00;
            eccf_r <= 6'h00;
            reload_r <= 16'h0000;
            run_r <= 1'b0;
        end else if (SFR_WR) begin
            if (SFR_ADDR == CTA_ADDR_MODE) mode_r <= SFR_WDATA;
            if (SFR_ADDR == CTA_ADDR_CTRL) run_r <= SFR_WDATA[CTA_CTRL_RUN_POS];
            if (SFR_ADDR == CTA_ADDR_RLD_HI) reload_r[15:8] <= SFR_WDATA;
            if (SFR_ADDR == CTA_ADDR_RLD_LO) reload_r[7:0] <= SFR_WDATA;
            if (SFR_ADDR >= CTA_ADDR_MOD0 && SFR_ADDR <= CTA_ADDR_MOD5)
                eccf_r[3'(SFR_ADDR - CTA_ADDR_MOD0)] <= SFR_WDATA[0];
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    AST_OE_LOW: assert property (OVERFLOW_CLOCK_OE == 1'b0)
        else $error("clock output enable raised");
    AST_STEP_ONE: assert property ($changed(TIME_BASE) && !$past(cnt_wr) &&
        !$past(cnt_wr, 2) && $past(TIME_BASE) != CTA_CNT_TOP |->
        TIME_BASE == $past(TIME_BASE) + 16'h0001)
        else $error("counter stepped by other than one");
    AST_RELOAD: assert property ($changed(TIME_BASE) && !$past(cnt_wr) &&
        !$past(cnt_wr, 2) && $past(TIME_BASE) == CTA_CNT_TOP |->
        TIME_BASE == $past(reload_r))
        else $error("counter not reloaded on overflow");
    AST_CLKOUT: assert property ($changed(OVERFLOW_CLOCK_OUT) |->
        $past(TIME_BASE, 2) == CTA_CNT_TOP)
        else $error("clock output toggled without overflow");
    AST_OVF_IRQ: assert property ($changed(TIME_BASE) && !$past(cnt_wr) &&
        !$past(cnt_wr, 2) && $past(TIME_BASE) == CTA_CNT_TOP && mode_r[0] |-> IRQ)
        else $error("overflow gave no interrupt");
    AST_IRQ_GATE: assert property (IRQ |-> $past(mode_r[0]) || $past(eccf_r) != 6'h00)
        else $error("interrupt with all enables off");
    AST_RUN_STOP: assert property (!$past(run_r) && !$past(cnt_wr) &&
        !$past(cnt_wr, 2) |-> $stable(TIME_BASE))
        else $error("counter moved while stopped");
    AST_IDLE_GATE: assert property ($past(mode_r[7] && IDLE) &&
        $past(mode_r[7] && IDLE, 2) && $past(mode_r[7] && IDLE, 3) && !$past(cnt_wr)
        && !$past(cnt_wr, 2) |-> $stable(TIME_BASE))
        else $error("counter moved while idle gated");
endmodule : cta_time_base_monitor

bind cta_time_base cta_time_base_monitor u_monitor (.CLK(CLK), .RST_B(RST_B),
    .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .IDLE(IDLE),
    .TIME_BASE(TIME_BASE), .OVERFLOW_CLOCK_OUT(OVERFLOW_CLOCK_OUT),
    .OVERFLOW_CLOCK_OE(OVERFLOW_CLOCK_OE), .IRQ(IRQ));

// ### testbench/cta_time_base_tb_top.sv
// Self-checking testbench of the counter array time base.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin errors++; \
    $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module cta_time_base_tb_top;
    import cta_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} cta_row_t;
    localparam cta_row_t ROWS [0:8] = '{'{8'hD9, 8'hA5, 8'hA5}, '{8'hDA, 8'h3C, 8'h3C},
        '{8'hDF, 8'hC3, 8'hC3}, '{8'hCF, 8'h12, 8'h12}, '{8'hCE, 8'h34, 8'h34},
        '{8'hF9, 8'h56, 8'h56}, '{8'hE9, 8'h78, 8'h78}, '{8'hA0, 8'hFF, 8'h00},
        '{8'hD8, 8'hBF, 8'hBF}};
    int errors = 0;
    int comparisons = 0;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [4:0] srcv = 5'h00;
    logic idle = 1'b0;
    logic [CTA_NMOD-1:0][15:0] cmp = {{4{16'h0000}}, 16'h0010, 16'h0010};
    logic [CTA_NMOD-1:0] pin_in = 6'h00;
    logic [CTA_NMOD-1:0] pin_owned, pin_out;
    logic [7:0] rdata, v;
    logic [15:0] tbase, t;
    logic [2:0] pbuf;
    logic ckout, ckoe, irq;
    always #2 clk = ~clk;
    cta_time_base dut (.CLK(clk), .RST_B(rst_b), .SFR_ADDR(addr), .SFR_WR(wr), .SFR_RD(rd),
        .SFR_WDATA(wdata), .SFR_RDATA(rdata), .COUNT_SOURCES(cta_srcs_t'(srcv)), .IDLE(idle),
        .MODULE_COMPARE(cmp), .MODULE_PIN_IN(pin_in), .MODULE_PIN_OWNED(pin_owned),
        .MODULE_PIN_OUT(pin_out), .TIME_BASE(tbase), .PAIR_BUFFER_ACTIVE(pbuf),
        .OVERFLOW_CLOCK_OUT(ckout), .OVERFLOW_CLOCK_OE(ckoe), .IRQ(irq));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr8
    task automatic rd8(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        d = rdata;
    endtask : rd8
    task automatic chk_reset;
        logic [7:0] r;
        foreach (ROWS[i]) begin
            rd8(ROWS[i].a, r);
            `CHK("reset register", 8'h00, r)
        end
        `CHK("reset count", 16'h0000, tbase)
        `CHK("reset irq", 1'b0, irq)
        $display("test reset done");
    endtask : chk_reset
    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #20000;
        errors++;
        report_and_stop();
    end
    initial begin
        int per [3] = '{12, 2, 1};
        logic [2:0] pcode [3] = '{3'h0, 3'h1, 3'h5};
        logic [2:0] ecode [5] = '{3'h2, 3'h6, 3'h3, 3'h4, 3'h7};
        int ebit [5] = '{4, 3, 2, 1, 0};
        int ehi [5] = '{1, 1, 4, 4, 4};
        cyc(2);
        rst_b = 1'b1;
        chk_reset();
        foreach (ROWS[i]) begin
            wr8(ROWS[i].a, ROWS[i].d);
            rd8(ROWS[i].a, v);
            `CHK("register readback", ROWS[i].e, v)
        end
        foreach (ROWS[i]) wr8(ROWS[i].a, 8'h00);
        $display("test registers done");
        // Overflow from all ones with reload value FFF0 and the system clock source.
        wr8(CTA_ADDR_RLD_HI, 8'hFF);
        wr8(CTA_ADDR_RLD_LO, 8'hF0);
        wr8(CTA_ADDR_CNT_HI, 8'hFF);
        wr8(CTA_ADDR_CNT_LO, 8'hFF);
        wr8(CTA_ADDR_MODE, 8'h0B);
        wr8(CTA_ADDR_CTRL, 8'h40);
        for (int i = 0; i < 20 && tbase !== 16'hFFF0; i++) cyc(1);
        `CHK("reloaded count", 16'hFFF0, tbase)
        `CHK("overflow irq", 1'b1, irq)
        cyc(1);
        `CHK("clock out", 1'b1, ckout)
        `CHK("clock out enable", 1'b0, ckoe)
        wr8(CTA_ADDR_CTRL, 8'h80);
        t = tbase;
        cyc(5);
        `CHK("stopped count", t, tbase)
        rd8(CTA_ADDR_CTRL, v);
        `CHK("sticky flag", 8'h80, v)
        wr8(CTA_ADDR_CTRL, 8'h00);
        rd8(CTA_ADDR_CTRL, v);
        `CHK("cleared flag", 8'h00, v)
        `CHK("irq after clear", 1'b0, irq)
        $display("test overflow done");
        wr8(CTA_ADDR_CNT_HI, 8'h00);
        wr8(CTA_ADDR_CNT_LO, 8'h00);
        foreach (pcode[i]) begin
            wr8(CTA_ADDR_MODE, {4'h0, pcode[i], 1'b0});
            wr8(CTA_ADDR_CTRL, 8'h40);
            cyc(4);
            t = tbase;
            cyc(48);
            `CHK("prescaled count", t + 16'(48 / per[i]), tbase)
        end
        foreach (ecode[i]) begin
            wr8(CTA_ADDR_MODE, {4'h0, ecode[i], 1'b0});
            cyc(8);
            t = tbase;
            repeat (3) begin
                srcv[ebit[i]] = 1'b1;
                cyc(ehi[i]);
                srcv[ebit[i]] = 1'b0;
                cyc(8);
            end
            cyc(8);
            `CHK("event count", t + 16'h0003, tbase)
        end
        $display("test sources done");
        for (int g = 1; g >= 0; g--) begin
            wr8(CTA_ADDR_MODE, {g[0], 7'h0A});
            idle = 1'b1;
            cyc(4);
            t = tbase;
            cyc(10);
            `CHK("idle count", g ? t : t + 16'h000A, tbase)
            idle = 1'b0;
        end
        $display("test idle done");
        wr8(CTA_ADDR_CTRL, 8'h00);
        wr8(CTA_ADDR_CNT_HI, 8'h00);
        wr8(CTA_ADDR_CNT_LO, 8'h00);
        wr8(CTA_ADDR_MOD0, 8'h4D);
        wr8(CTA_ADDR_MOD0 + 8'h01, 8'h44);
        wr8(CTA_ADDR_CTRL, 8'h40);
        cyc(40);
        rd8(CTA_ADDR_CTRL, v);
        `CHK("match flags", 8'h41, v)
        `CHK("module irq", 1'b1, irq)
        `CHK("toggled pins", 2'b11, pin_out[1:0])
        `CHK("owned pins", 6'h03, pin_owned)
        wr8(CTA_ADDR_CTRL, 8'h00);
        cyc(2);
        `CHK("module irq cleared", 1'b0, irq)
        $display("test match done");
        wr8(CTA_ADDR_MOD0 + 8'h02, 8'h10);
        pin_in[2] = 1'b1;
        cyc(3);
        pin_in[2] = 1'b0;
        cyc(3);
        rd8(CTA_ADDR_CTRL, v);
        `CHK("capture flag", 8'h04, v)
        wr8(CTA_ADDR_MOD0, 8'h02);
        wr8(CTA_ADDR_MOD0 + 8'h01, 8'h20);
        wr8(CTA_ADDR_MODE, 8'h10);
        cyc(2);
        `CHK("pair buffer on", 3'b001, pbuf)
        wr8(CTA_ADDR_MOD0 + 8'h01, 8'h04);
        cyc(2);
        `CHK("pair buffer off", 3'b000, pbuf)
        $display("test capture and buffer done");
        rst_b = 1'b0;
        cyc(2);
        rst_b = 1'b1;
        chk_reset();
        report_and_stop();
    end
endmodule : cta_time_base_tb_top
